/* File: src/madc_params.svh */
`ifndef MADC_PARAMS_SVH
`define MADC_PARAMS_SVH

// ----------------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------------
`define MADC_CLK_NS 40
`define MADC_RST_MIN_NS 40
`define MADC_RST_MIN_CYC ((`MADC_RST_MIN_NS + `MADC_CLK_NS - 1) / `MADC_CLK_NS)
`define MADC_INIT_CYCLES 1024
`define MADC_PD_CYCLES 65536

// ----------------------------------------------------------------------
// serial frame layout
// ----------------------------------------------------------------------
`define MADC_WORD_BITS 24
`define MADC_FRAME_NORM 128
`define MADC_FRAME_DBL 64
`define MADC_WIDE_THRESH 96
`define MADC_HALF_DIV4 2
`define MADC_HALF_DIV8 4

// ----------------------------------------------------------------------
// high-pass filter
// ----------------------------------------------------------------------
`define MADC_HPF_SHIFT 13

`endif

/* File: src/madc_pkg.sv */
package madc_pkg;

    // ------------------------------------------------------------------
    // modes and states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        MADC_RATE_DBL,
        MADC_RATE_LOWPWR,
        MADC_RATE_HIPERF
    } madc_rate_e;

    typedef enum logic [2:0] {
        MADC_ST_WAIT_CLK,
        MADC_ST_INIT,
        MADC_ST_RUN,
        MADC_ST_HOLD,
        MADC_ST_PDOWN
    } madc_state_e;

    // ------------------------------------------------------------------
    // serial port pins
    // ------------------------------------------------------------------
    typedef struct packed {
        logic data;
        logic fs_out;
        logic fs_oe;
        logic bck_out;
        logic bck_oe;
    } madc_pins_s;

endpackage : madc_pkg

/* File: src/madc_hpf.sv */
`timescale 1ns/10ps
`include "madc_params.svh"

module madc_hpf import madc_pkg::*; #(
    parameter int W = `MADC_WORD_BITS,
    parameter int K = `MADC_HPF_SHIFT
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // control
    input wire logic bypass,
    // sample in
    input wire logic in_valid,
    input wire logic signed [W-1:0] in_data,
    // sample out
    output logic out_valid_ff,
    output logic signed [W-1:0] out_data_ff
);

    localparam int AW = W + K + 2;
    localparam logic signed [AW-1:0] MAXV = AW'((1 << (W - 1)) - 1);
    localparam logic signed [AW-1:0] MINV = -AW'(1 << (W - 1));

    logic signed [AW-1:0] acc_ff, nxt_acc;
    logic signed [W-1:0] prev_ff, nxt_prev;
    logic signed [W-1:0] nxt_out;
    logic nxt_valid;
    logic signed [AW-1:0] diff;
    logic signed [AW-1:0] y;

    // ------------------------------------------------------------------
    // one-pole dc blocker, pole 1 - 2^-k
    // ------------------------------------------------------------------
    always_comb begin
        diff = AW'(in_data) - AW'(prev_ff);
        y = acc_ff >>> K;
        nxt_acc = acc_ff;
        nxt_prev = prev_ff;
        nxt_out = out_data_ff;
        nxt_valid = in_valid;
        if (in_valid) begin
            nxt_acc = acc_ff - (acc_ff >>> K) + (diff <<< K);
            nxt_prev = in_data;
            if (bypass) begin
                nxt_out = in_data;
            end else if (y > MAXV) begin
                nxt_out = MAXV[W-1:0];
            end else if (y < MINV) begin
                nxt_out = MINV[W-1:0];
            end else begin
                nxt_out = y[W-1:0];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            acc_ff <= '0;
            prev_ff <= '0;
            out_data_ff <= '0;
            out_valid_ff <= 1'b0;
        end else begin
            acc_ff <= nxt_acc;
            prev_ff <= nxt_prev;
            out_data_ff <= nxt_out;
            out_valid_ff <= nxt_valid;
        end
    end

endmodule : madc_hpf

/* File: src/madc_port.sv */
`timescale 1ns/10ps
`include "madc_params.svh"

module madc_port import madc_pkg::*; #(
    parameter int PD_CYCLES = `MADC_PD_CYCLES,
    parameter int INIT_CYCLES = `MADC_INIT_CYCLES
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // device control pins
    input wire logic rst_pin_n,
    input wire logic clk_running,
    input wire logic master_sel,
    input wire madc_rate_e rate_sel,
    input wire logic highpass_disable,
    // samples from the decimator
    input wire logic sample_valid,
    input wire logic [`MADC_WORD_BITS-1:0] sample_data,
    // serial port
    input wire logic frame_sync_clock_in,
    input wire logic bit_clock_in,
    output madc_pins_s pins_ff,
    // status
    output logic init_done_ff,
    output logic power_down_ff
);

    localparam int WB = `MADC_WORD_BITS;
    localparam int PW = $clog2(PD_CYCLES + 1);
    localparam int IW = $clog2(INIT_CYCLES + 1);

    madc_state_e st_ff, nxt_st;
    logic [PW-1:0] low_cnt_ff, nxt_low_cnt;
    logic [IW-1:0] init_cnt_ff, nxt_init_cnt;
    logic rst_prev_ff, master_ff, nxt_master;

    // ------------------------------------------------------------------
    // reset, init and power-down sequencing
    // ------------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_low_cnt = low_cnt_ff;
        nxt_init_cnt = init_cnt_ff;
        nxt_master = master_ff;
        case (st_ff)
            MADC_ST_WAIT_CLK: begin
                if (clk_running) begin
                    nxt_st = MADC_ST_INIT;
                    nxt_init_cnt = '0;
                end
            end
            MADC_ST_INIT: begin
                nxt_init_cnt = init_cnt_ff + IW'(1);
                if (init_cnt_ff == IW'(INIT_CYCLES - 1)) begin
                    nxt_st = MADC_ST_RUN;
                end
            end
            MADC_ST_RUN: begin
            end
            MADC_ST_HOLD, MADC_ST_PDOWN: begin
                if (rst_pin_n && low_cnt_ff >= PW'(`MADC_RST_MIN_CYC)) begin
                    nxt_st = MADC_ST_INIT;
                    nxt_init_cnt = '0;
                end
            end
            default: nxt_st = MADC_ST_WAIT_CLK;
        endcase
        if (!rst_pin_n) begin
            if (low_cnt_ff != PW'(PD_CYCLES)) begin
                nxt_low_cnt = low_cnt_ff + PW'(1);
            end
            nxt_st = (nxt_low_cnt == PW'(PD_CYCLES)) ? MADC_ST_PDOWN : MADC_ST_HOLD;
        end else if (rst_prev_ff) begin
            nxt_low_cnt = '0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st_ff <= MADC_ST_WAIT_CLK;
            low_cnt_ff <= '0;
            init_cnt_ff <= '0;
            rst_prev_ff <= 1'b1;
            master_ff <= master_sel;
        end else begin
            st_ff <= nxt_st;
            low_cnt_ff <= nxt_low_cnt;
            init_cnt_ff <= nxt_init_cnt;
            rst_prev_ff <= rst_pin_n;
            master_ff <= nxt_master;
        end
    end

    // ------------------------------------------------------------------
    // sample path through the high-pass filter
    // ------------------------------------------------------------------
    logic hpf_valid;
    logic [WB-1:0] hpf_data;
    logic [WB-1:0] word_ff, nxt_word;

    madc_hpf #(.W(WB), .K(`MADC_HPF_SHIFT)) u_hpf (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .bypass(highpass_disable),
        .in_valid(sample_valid),
        .in_data(sample_data),
        .out_valid_ff(hpf_valid),
        .out_data_ff(hpf_data)
    );

    // ------------------------------------------------------------------
    // bit and frame timing
    // ------------------------------------------------------------------
    logic [2:0] div_ff, nxt_div;
    logic [7:0] bit_ff, nxt_bit;
    logic bck_prev_ff, fs_prev_ff, wide_ff, nxt_wide;
    logic [7:0] span_ff, nxt_span;
    logic [WB-1:0] shift_ff, nxt_shift;
    logic [4:0] left_ff, nxt_left;
    madc_pins_s nxt_pins;
    logic [2:0] half;
    logic [7:0] flen;
    logic clocks_on, bck_fall, start, invert, enable;

    always_comb begin
        nxt_word = hpf_valid ? hpf_data : word_ff;
        half = (rate_sel == MADC_RATE_LOWPWR) ? 3'(`MADC_HALF_DIV8) : 3'(`MADC_HALF_DIV4);
        flen = (rate_sel == MADC_RATE_DBL) ? 8'(`MADC_FRAME_DBL) : 8'(`MADC_FRAME_NORM - 1);
        if (rate_sel != MADC_RATE_DBL) begin
            flen = (master_ff && rate_sel == MADC_RATE_LOWPWR) ?
                8'(`MADC_FRAME_DBL) : 8'(`MADC_FRAME_NORM);
        end
        clocks_on = st_ff != MADC_ST_PDOWN && st_ff != MADC_ST_WAIT_CLK;
        invert = !master_ff && rate_sel == MADC_RATE_LOWPWR && wide_ff;
        nxt_pins = pins_ff;
        nxt_div = div_ff;
        nxt_bit = bit_ff;
        nxt_wide = wide_ff;
        nxt_shift = shift_ff;
        nxt_left = left_ff;
        nxt_span = span_ff;
        bck_fall = 1'b0;
        start = 1'b0;
        nxt_pins.fs_oe = master_ff;
        nxt_pins.bck_oe = master_ff;
        if (master_ff) begin
            if (!clocks_on) begin
                nxt_div = '0;
                nxt_pins.bck_out = 1'b0;
            end else if (div_ff == half - 3'd1) begin
                nxt_div = '0;
                nxt_pins.bck_out = !pins_ff.bck_out;
                bck_fall = pins_ff.bck_out;
            end else begin
                nxt_div = div_ff + 3'd1;
            end
            if (bck_fall) begin
                nxt_bit = (bit_ff == flen - 8'd1) ? 8'd0 : bit_ff + 8'd1;
                start = bit_ff == flen - 8'd1;
                nxt_pins.fs_out = nxt_bit < (flen >> 1);
            end
            if (!clocks_on) begin
                nxt_pins.fs_out = 1'b0;
                nxt_bit = flen - 8'd1;
            end
        end else begin
            nxt_pins.bck_out = 1'b0;
            nxt_pins.fs_out = 1'b0;
            bck_fall = clocks_on && bck_prev_ff && !bit_clock_in;
            if (bck_fall) begin
                start = (frame_sync_clock_in != fs_prev_ff) &&
                        (frame_sync_clock_in != invert);
                nxt_bit = (bit_ff == 8'hff) ? bit_ff : bit_ff + 8'd1;
                if (start) begin
                    nxt_bit = 8'd0;
                end
                // rise-to-rise count, independent of which edge opens a frame
                nxt_span = (span_ff == 8'hff) ? span_ff : span_ff + 8'd1;
                if (frame_sync_clock_in != fs_prev_ff && frame_sync_clock_in) begin
                    nxt_wide = span_ff >= 8'(`MADC_WIDE_THRESH - 1);
                    nxt_span = 8'd0;
                end
            end
        end
        // hiperf slave on a 64fs bit clock stays silent
        enable = st_ff == MADC_ST_RUN && rst_pin_n &&
                 !(!master_ff && rate_sel == MADC_RATE_HIPERF && !wide_ff);
        if (start) begin
            nxt_shift = {word_ff[WB-2:0], 1'b0};
            nxt_left = 5'(WB - 1);
            nxt_pins.data = enable & word_ff[WB-1];
        end else if (bck_fall) begin
            if (left_ff != 5'd0) begin
                nxt_pins.data = enable & shift_ff[WB-1];
                nxt_shift = {shift_ff[WB-2:0], 1'b0};
                nxt_left = left_ff - 5'd1;
            end else begin
                nxt_pins.data = 1'b0;
            end
        end
        if (!enable) begin
            nxt_pins.data = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            word_ff <= '0;
            div_ff <= '0;
            bit_ff <= '0;
            bck_prev_ff <= 1'b0;
            fs_prev_ff <= 1'b0;
            wide_ff <= 1'b1;
            span_ff <= '0;
            shift_ff <= '0;
            left_ff <= '0;
            pins_ff <= '0;
            init_done_ff <= 1'b0;
            power_down_ff <= 1'b0;
        end else begin
            word_ff <= nxt_word;
            div_ff <= nxt_div;
            bit_ff <= nxt_bit;
            bck_prev_ff <= bit_clock_in;
            fs_prev_ff <= bck_fall ? frame_sync_clock_in : fs_prev_ff;
            wide_ff <= nxt_wide;
            span_ff <= nxt_span;
            shift_ff <= nxt_shift;
            left_ff <= nxt_left;
            pins_ff <= nxt_pins;
            init_done_ff <= nxt_st == MADC_ST_RUN;
            power_down_ff <= nxt_st == MADC_ST_PDOWN;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    sequence s_init_end;
        st_ff == MADC_ST_INIT && init_cnt_ff == IW'(INIT_CYCLES - 1) && rst_pin_n;
    endsequence

    a_wait_for_clock: assert property (st_ff == MADC_ST_WAIT_CLK && !clk_running && rst_pin_n
        |=> st_ff == MADC_ST_WAIT_CLK) else $error("init began without clock");
    a_init_to_run: assert property (s_init_end |=> st_ff == MADC_ST_RUN && init_done_ff)
        else $error("init did not finish on time");
    a_init_data_low: assert property (st_ff == MADC_ST_INIT |=> !pins_ff.data)
        else $error("data high during init");
    a_reset_restart: assert property ($rose(rst_pin_n) && st_ff == MADC_ST_HOLD
        |=> st_ff == MADC_ST_INIT ##1 init_cnt_ff == IW'(1))
        else $error("reset release did not restart init");
    a_pdown_entry: assert property (!rst_pin_n && low_cnt_ff == PW'(PD_CYCLES - 1)
        |=> power_down_ff && st_ff == MADC_ST_PDOWN) else $error("no power-down");
    a_pdown_quiet: assert property (st_ff == MADC_ST_PDOWN |=> !pins_ff.data && !pins_ff.bck_out)
        else $error("activity in power-down");
    a_frame_msb: assert property (start && enable |=> pins_ff.data == $past(word_ff[WB-1]))
        else $error("frame did not open with msb");
    a_tail_low: assert property (bck_fall && !start && left_ff == 5'd0 |=> !pins_ff.data)
        else $error("data high after last bit");
    a_hiperf_mute: assert property (!master_ff && rate_sel == MADC_RATE_HIPERF && !wide_ff
        |=> !pins_ff.data) else $error("output on 64fs hiperf");
    a_master_drive: assert property (master_ff |=> pins_ff.fs_oe && pins_ff.bck_oe)
        else $error("master not driving clocks");
    a_master_duty: assert property (master_ff && bck_fall && bit_ff == (flen >> 1) - 8'd1
        |=> !pins_ff.fs_out) else $error("frame sync not half duty");

endmodule : madc_port

/* File: test/madc_frame_gen.sv */
`timescale 1ns/10ps

// ----------------------------------------------------------------------
// slave-mode timing master model
// ----------------------------------------------------------------------
module madc_frame_gen #(
    parameter int HALF = 6
) (
    // clock
    input wire logic sys_clk,
    // control
    input wire logic run,
    input wire logic [7:0] nbits,
    // serial clocks
    output logic fs,
    output logic bit_clock
);
    int ph;
    int bit_i;

    initial begin
        fs = 1'b0;
        bit_clock = 1'b0;
        ph = 0;
        bit_i = 0;
    end

    always @(posedge sys_clk) begin : gen_step
        int nxt;
        nxt = (bit_i + 1 >= int'(nbits)) ? 0 : bit_i + 1;
        if (!run) begin // clocks stand still outside a run
            bit_clock <= 1'b0;
            fs <= 1'b0;
            ph <= 0;
            bit_i <= 0;
        end else if (ph == HALF - 1) begin
            ph <= 0;
            bit_clock <= !bit_clock; // bits per frame set by the bench
            if (bit_clock) begin // sync moves on a falling bit clock, half high
                bit_i <= nxt;
                fs <= (nxt < int'(nbits) / 2);
            end
        end else begin
            ph <= ph + 1;
        end
    end
endmodule : madc_frame_gen

/* File: test/test_mono_adc_serial_output_port.sv */
`timescale 1ns/10ps
`include "madc_params.svh"

module test_mono_adc_serial_output_port import madc_pkg::*;;
    localparam int INIT = 16;
    localparam int PD = 64;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic rst_pin_n = 1'b1;
    logic clk_running = 1'b0;
    logic master_sel = 1'b0;
    madc_rate_e rate_sel = MADC_RATE_HIPERF;
    logic highpass_disable = 1'b1;
    logic sample_valid = 1'b0;
    logic [`MADC_WORD_BITS-1:0] sample_data = '0;
    logic [23:0] word = 24'h9a5c31;
    logic gen_run = 1'b0;
    logic [7:0] gen_bits = 8'h80;
    logic fs_in, bck_in, fs_w, bck_w;
    madc_pins_s pins_ff;
    logic init_done_ff, power_down_ff;
    int miscompares = 0;
    int samples_checked = 0;
    int cyc = 0;

    // bit clock of sys/4: 128fs at 128 bits, 64fs at 64 bits
    madc_frame_gen #(.HALF(2)) partner (.sys_clk(sys_clk), .run(gen_run),
        .nbits(gen_bits), .fs(fs_in), .bit_clock(bck_in));
    madc_port #(.PD_CYCLES(PD), .INIT_CYCLES(INIT)) dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .rst_pin_n(rst_pin_n), .clk_running(clk_running), .master_sel(master_sel),
        .rate_sel(rate_sel), .highpass_disable(highpass_disable), .sample_valid(sample_valid),
        .sample_data(sample_data), .frame_sync_clock_in(fs_in), .bit_clock_in(bck_in),
        .pins_ff(pins_ff), .init_done_ff(init_done_ff), .power_down_ff(power_down_ff));

    assign fs_w = master_sel ? pins_ff.fs_out : fs_in;
    assign bck_w = master_sel ? pins_ff.bck_out : bck_in;

    always #20 sys_clk = ~sys_clk;

    // ------------------------------------------------------------------
    // sample feed and hang guard
    // ------------------------------------------------------------------
    always @(posedge sys_clk) begin
        #2;
        cyc++;
        sample_valid = (cyc % 64 == 0);
        sample_data = word;
        if (cyc == 90000) begin
            miscompares++;
            $display("timeout");
            tally_and_finish();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask : tick

    task automatic chk(input string what, input logic [127:0] exp, input logic [127:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
            miscompares++;
        end
    endtask : chk

    task automatic restart(input logic mst, input madc_rate_e r, input logic run);
        tick(1);
        sys_rst = 1'b1;
        master_sel = mst;
        rate_sel = r;
        gen_run = run;
        tick(5);
        sys_rst = 1'b0;
    endtask : restart

    // cycles until init_done, data watched meanwhile
    task automatic wait_init(output int n);
        n = 0;
        while (init_done_ff !== 1'b1 && n < 300) begin
            if (pins_ff.data !== 1'b0) chk("data during init", 0, 1);
            tick(1);
            n++;
        end
    endtask : wait_init

    // wait for the third frame start, then collect bits on rising bit clock
    task automatic grab(input bit inv, input int nb, output logic [127:0] bits);
        logic pf, pb;
        int n;
        bits = '0;
        n = 0;
        pf = fs_w;
        while (n < 3) begin
            tick(1);
            if (fs_w !== pf && fs_w === !inv) n++;
            pf = fs_w;
        end
        pb = bck_w;
        n = 0;
        while (n < nb) begin
            tick(1);
            if (bck_w === 1'b1 && pb === 1'b0) begin
                bits[127-n] = pins_ff.data;
                n++;
            end
            pb = bck_w;
        end
    endtask : grab

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic test_init();
        int n;
        restart(1'b0, MADC_RATE_HIPERF, 1'b1);
        tick(40);
        chk("init without clock", 0, init_done_ff);
        clk_running = 1'b1;
        wait_init(n);
        chk("init length ok", 1, (n >= INIT && n <= INIT + 3));
        $display("test_init done");
    endtask : test_init

    task automatic test_master();
        madc_rate_e rt[3] = '{MADC_RATE_HIPERF, MADC_RATE_LOWPWR, MADC_RATE_DBL};
        int nb[3] = '{128, 64, 64};
        int hf[3] = '{2, 4, 2};
        int n, hi, per, rises;
        logic pf, pb, done;
        logic [127:0] bits;
        for (int i = 0; i < 3; i++) begin
            restart(1'b1, rt[i], 1'b0);
            wait_init(n);
            master_sel = 1'b0;
            tick(1);
            master_sel = 1'b1;
            chk("clock enables", 2'b11, {pins_ff.fs_oe, pins_ff.bck_oe});
            grab(1'b0, nb[i], bits);
            chk("master word", word, bits[127:104]);
            chk("master tail", 0, bits[103:0]);
            while (fs_w !== 1'b1) tick(1);
            while (fs_w !== 1'b0) tick(1);
            while (fs_w !== 1'b1) tick(1);
            hi = 0;
            per = 0;
            rises = 0;
            pf = fs_w;
            pb = bck_w;
            done = 1'b0;
            while (!done) begin
                tick(1);
                per++;
                if (fs_w === 1'b1) hi++;
                if (bck_w === 1'b1 && pb === 1'b0) rises++;
                done = fs_w === 1'b1 && pf === 1'b0;
                pf = fs_w;
                pb = bck_w;
            end
            chk("frame period", nb[i] * 2 * hf[i], per);
            chk("sync high time", nb[i] * hf[i], hi);
            chk("bits per frame", nb[i], rises);
        end
        $display("test_master done");
    endtask : test_master

    task automatic test_slave();
        madc_rate_e rt[5] = '{MADC_RATE_HIPERF, MADC_RATE_LOWPWR, MADC_RATE_LOWPWR,
            MADC_RATE_DBL, MADC_RATE_HIPERF};
        int nb[5] = '{128, 128, 64, 64, 64};
        bit inv[5] = '{0, 1, 0, 0, 0};
        int n;
        logic [127:0] bits;
        word = 24'h400001;
        for (int i = 0; i < 5; i++) begin
            gen_bits = nb[i][7:0];
            restart(1'b0, rt[i], 1'b1);
            wait_init(n);
            chk("slave enables", 0, {pins_ff.fs_oe, pins_ff.bck_oe});
            grab(inv[i], nb[i], bits);
            chk("slave word", (i == 4) ? 0 : word, bits[127:104]);
            chk("slave tail", 0, bits[103:0]);
        end
        $display("test_slave done");
    endtask : test_slave

    task automatic test_rstpin();
        int n;
        restart(1'b1, MADC_RATE_DBL, 1'b0);
        wait_init(n);
        rst_pin_n = 1'b0;
        tick(1);
        rst_pin_n = 1'b1;
        tick(1);
        chk("init restarted", 0, init_done_ff);
        wait_init(n);
        chk("reinit length", 1, (n >= INIT - 2 && n <= INIT + 3));
        rst_pin_n = 1'b0;
        n = 0;
        while (power_down_ff !== 1'b1 && n < 200) begin
            tick(1);
            n++;
            if (pins_ff.data !== 1'b0) chk("data in hold", 0, 1);
        end
        chk("power-down delay", 1, (n >= PD - 1 && n <= PD + 3));
        tick(20);
        chk("power-down data", 2'b10, {power_down_ff, pins_ff.data});
        rst_pin_n = 1'b1;
        wait_init(n);
        chk("wake init", 1, (n >= INIT && n <= INIT + 4));
        chk("power-down left", 0, power_down_ff);
        $display("test_rstpin done");
    endtask : test_rstpin

    // constant input through the enabled filter must fall away
    task automatic test_hpf();
        int n;
        logic [127:0] b1, b2;
        word = 24'h400001;
        highpass_disable = 1'b0;
        gen_bits = 8'h40;
        restart(1'b0, MADC_RATE_DBL, 1'b1);
        wait_init(n);
        grab(1'b0, 24, b1);
        grab(1'b0, 24, b2);
        chk("filtered below input", 1, (b1[127:104] < word));
        chk("filtered decays", 1, (b2[127:104] < b1[127:104]));
        highpass_disable = 1'b1;
        $display("test_hpf done");
    endtask : test_hpf

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        test_init();
        test_master();
        test_slave();
        test_hpf();
        test_rstpin();
        tally_and_finish();
    end
endmodule : test_mono_adc_serial_output_port
